// [fbsp_cfg.svh]
`ifndef FBSP_CFG_SVH
`define FBSP_CFG_SVH
`define FBSP_ADDR_W 19
`define FBSP_DATA_W 32
`define FBSP_LANES 4
`define FBSP_LANE_W 8
`define FBSP_DEPTH 524288
`define FBSP_BURST_LEN 4
`endif

// [fbsp_pkg.sv]
`default_nettype none
`include "fbsp_cfg.svh"
package fbsp_pkg;
	typedef logic [`FBSP_ADDR_W-1:0] fbsp_addr_t;
	typedef logic [`FBSP_DATA_W-1:0] fbsp_data_t;
	typedef logic [`FBSP_LANES-1:0] fbsp_lane_t;
	typedef enum logic {FBSP_LINEAR, FBSP_INTERLEAVED} fbsp_order_t;
	typedef enum {FBSP_IDLE, FBSP_READ, FBSP_WRITE} fbsp_cyc_t;
	function automatic logic [1:0] fbsp_burst_addr(input logic [1:0] start, input logic [1:0] beat,
		input logic interleaved);
		logic [1:0] r;
		r = interleaved ? (start ^ beat) : 2'(start + beat);
		return r;
	endfunction
endpackage
`default_nettype wire

// [fbsp_if.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fbsp_cfg.svh"
interface fbsp_if;
	import fbsp_pkg::*;
	logic [`FBSP_ADDR_W-1:0] addr;
	logic controller_addr_strobe_n;
	logic processor_addr_strobe_n;
	logic chip_select_first_n;
	logic burst_advance_n;
	logic all_bytes_write_n;
	logic byte_lane_write_enable_n;
	logic [`FBSP_LANES-1:0] byte_lane_select_n;
	logic output_enable_n;
	logic sleep_request;
	logic burst_order;
	logic [`FBSP_DATA_W-1:0] dq_host;
	logic [`FBSP_LANES-1:0] parity_host;
	logic dq_host_oe;
	logic [`FBSP_DATA_W-1:0] dq_dev;
	logic [`FBSP_LANES-1:0] parity_dev;
	logic dq_dev_oe;
	modport device(input addr, controller_addr_strobe_n, processor_addr_strobe_n,
		chip_select_first_n, burst_advance_n, all_bytes_write_n, byte_lane_write_enable_n,
		byte_lane_select_n, output_enable_n, sleep_request, burst_order, dq_host, parity_host,
		dq_host_oe, output dq_dev, parity_dev, dq_dev_oe);
	modport host(output addr, controller_addr_strobe_n, processor_addr_strobe_n,
		chip_select_first_n, burst_advance_n, all_bytes_write_n, byte_lane_write_enable_n,
		byte_lane_select_n, output_enable_n, sleep_request, burst_order, dq_host, parity_host,
		dq_host_oe, input dq_dev, parity_dev, dq_dev_oe);
endinterface
`default_nettype wire

// [fbsp_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module fbsp_sync (
	input wire logic i_clk,
	input wire logic i_d,
	output logic o_q
);
	logic meta;
	logic q;
	always_ff @(posedge i_clk) begin
		meta <= i_d;
		q <= meta;
	end
	assign o_q = q;
endmodule
`default_nettype wire

// [fbsp_device.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fbsp_cfg.svh"
module fbsp_device
	import fbsp_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_srst,
	fbsp_if.device bus,
	output logic o_sleeping,
	output logic o_burst_interleaved
);
	localparam int LW = `FBSP_LANE_W;
	localparam int PW = LW + 1;

	logic [PW-1:0] mem [0:`FBSP_DEPTH-1][0:`FBSP_LANES-1];

	////////////////////////////////////////////////////////////////////////////////
	// asynchronous pins pass a two-stage synchroniser first
	logic sleep_s;
	logic oe_n_s;
	logic order_s;
	fbsp_sync u_sync_sleep (.i_clk(i_clk), .i_d(bus.sleep_request), .o_q(sleep_s));
	fbsp_sync u_sync_oe (.i_clk(i_clk), .i_d(bus.output_enable_n), .o_q(oe_n_s));
	fbsp_sync u_sync_order (.i_clk(i_clk), .i_d(bus.burst_order), .o_q(order_s));

	// x or z on a pin stands for an open pin: pull-down / pull-up
	logic sleep_in;
	logic order_in;
	always_comb begin
		sleep_in = (sleep_s === 1'b1);
		order_in = (order_s !== 1'b0);
	end

	////////////////////////////////////////////////////////////////////////////////
	// address, burst counter and cycle state
	logic [`FBSP_ADDR_W-1:0] base;
	logic [1:0] start;
	logic [1:0] beat;
	fbsp_cyc_t cyc;
	logic deselected;
	logic first_sel;
	logic [`FBSP_ADDR_W-1:0] next_base;
	logic [1:0] next_start;
	logic [1:0] next_beat;
	fbsp_cyc_t next_cyc;
	logic next_deselected;
	logic next_first_sel;
	logic strobe;
	logic proc_ok;
	logic wr_now;

	always_comb begin
		next_base = base;
		next_start = start;
		next_beat = beat;
		next_cyc = cyc;
		next_deselected = deselected;
		next_first_sel = 1'b0;
		proc_ok = !bus.processor_addr_strobe_n && !bus.chip_select_first_n;
		// processor strobe takes priority; controller strobe alone otherwise
		strobe = proc_ok || !bus.controller_addr_strobe_n;
		// enable low marks a write cycle even with no lane picked: pins stay quiet
		wr_now = !bus.all_bytes_write_n || !bus.byte_lane_write_enable_n;
		if (sleep_in) begin
			next_cyc = FBSP_IDLE;
			next_deselected = 1'b1;
		end else if (strobe) begin
			if (bus.chip_select_first_n) begin
				next_cyc = FBSP_IDLE;
				next_deselected = 1'b1;
			end else begin
				next_base = bus.addr;
				next_start = bus.addr[1:0];
				next_beat = 2'h0;
				// processor strobe cycle is read first; writes follow via controls
				next_cyc = (proc_ok || !wr_now) ? FBSP_READ : FBSP_WRITE;
				next_first_sel = deselected;
				next_deselected = 1'b0;
			end
		end else if (!deselected) begin
			if (!bus.burst_advance_n) begin
				next_beat = 2'(beat + 2'h1);
			end
			next_cyc = wr_now ? FBSP_WRITE : FBSP_READ;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			base <= '0;
			start <= 2'h0;
			beat <= 2'h0;
			cyc <= FBSP_IDLE;
			deselected <= 1'b1;
			first_sel <= 1'b0;
		end else begin
			base <= next_base;
			start <= next_start;
			beat <= next_beat;
			cyc <= next_cyc;
			deselected <= next_deselected;
			first_sel <= next_first_sel;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// current burst address
	logic [`FBSP_ADDR_W-1:0] cur_addr;
	always_comb begin
		cur_addr = {base[`FBSP_ADDR_W-1:2], fbsp_burst_addr(start, beat, order_in)};
	end

	////////////////////////////////////////////////////////////////////////////////
	// write lane enables registered with the address, delayed to meet the data
	logic [`FBSP_LANES-1:0] lane_we;
	logic [`FBSP_LANES-1:0] next_lane_we;
	logic [`FBSP_DATA_W-1:0] wdata;
	logic [`FBSP_LANES-1:0] wpar;
	logic [`FBSP_LANES-1:0] wr_lanes;
	logic [`FBSP_LANES-1:0] next_wr_lanes;
	logic [`FBSP_ADDR_W-1:0] waddr;
	always_comb begin
		if (!bus.all_bytes_write_n) begin
			next_lane_we = '1;
		end else if (!bus.byte_lane_write_enable_n) begin
			next_lane_we = ~bus.byte_lane_select_n;
		end else begin
			next_lane_we = '0;
		end
		if (sleep_in || (strobe && bus.chip_select_first_n)) begin
			next_lane_we = '0;
		end
		// lanes armed at the address edge fire once the data edge has passed
		next_wr_lanes = (cyc == FBSP_WRITE && !sleep_in) ? lane_we : '0;
	end

	// self-timed write: the data register loads on the edge after the address,
	// the array takes it one edge later so the register is never bypassed
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			lane_we <= '0;
			wr_lanes <= '0;
			waddr <= '0;
			wdata <= '0;
			wpar <= '0;
		end else begin
			lane_we <= next_lane_we;
			wr_lanes <= next_wr_lanes;
			waddr <= cur_addr;
			wdata <= bus.dq_host;
			wpar <= bus.parity_host;
		end
	end

	// one process owns the array, so every lane shares a single driver
	always_ff @(posedge i_clk) begin
		for (int i = 0; i < `FBSP_LANES; i++) begin
			if (wr_lanes[i] && !sleep_in) begin
				mem[waddr][i] <= {wpar[i], wdata[i*LW +: LW]};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// flow-through read path, drive enable registered
	logic [`FBSP_DATA_W-1:0] rdata;
	logic [`FBSP_LANES-1:0] rpar;
	logic drive;
	logic next_drive;
	always_comb begin
		for (int i = 0; i < `FBSP_LANES; i++) begin
			rdata[i*LW +: LW] = mem[cur_addr][i][LW-1:0];
			rpar[i] = mem[cur_addr][i][LW];
		end
		next_drive = !oe_n_s && (next_cyc == FBSP_READ) && !next_first_sel;
		if (next_cyc == FBSP_WRITE) begin
			next_drive = 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			drive <= 1'b0;
		end else begin
			drive <= next_drive;
		end
	end

	// read data follows the address combinationally, as a flow-through part does
	assign bus.dq_dev = rdata;
	assign bus.parity_dev = rpar;
	assign bus.dq_dev_oe = drive;

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_sleeping <= 1'b0;
			o_burst_interleaved <= 1'b1;
		end else begin
			o_sleeping <= sleep_in;
			o_burst_interleaved <= order_in;
		end
	end
endmodule
`default_nettype wire

// [fbsp_host.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fbsp_cfg.svh"
module fbsp_host
	import fbsp_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_srst,
	fbsp_if.host bus,
	input wire logic i_req,
	input wire logic i_write,
	input wire logic i_use_processor,
	input wire logic [`FBSP_ADDR_W-1:0] i_addr,
	input wire logic [`FBSP_DATA_W-1:0] i_wdata,
	input wire logic [`FBSP_LANES-1:0] i_wpar,
	input wire logic [`FBSP_LANES-1:0] i_lanes,
	input wire logic i_all_bytes,
	input wire logic i_sleep,
	input wire logic i_interleaved,
	output logic o_busy,
	output logic o_rvalid,
	output logic [`FBSP_DATA_W-1:0] o_rdata,
	output logic [`FBSP_LANES-1:0] o_rpar
);
	typedef enum {FBSP_H_IDLE, FBSP_H_ADDR, FBSP_H_DATA, FBSP_H_TURN} fbsp_hst_t;
	fbsp_hst_t st;
	fbsp_hst_t next_st;
	logic wr;
	logic next_wr;
	always_comb begin
		next_st = st;
		next_wr = wr;
		case (st)
			FBSP_H_IDLE: begin
				if (i_req) begin
					next_st = FBSP_H_ADDR;
					next_wr = i_write;
				end
			end
			FBSP_H_ADDR: next_st = FBSP_H_DATA;
			FBSP_H_DATA: next_st = FBSP_H_TURN;
			FBSP_H_TURN: next_st = FBSP_H_IDLE;
			default: next_st = FBSP_H_IDLE;
		endcase
	end
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			st <= FBSP_H_IDLE;
			wr <= 1'b0;
			bus.addr <= '0;
			bus.controller_addr_strobe_n <= 1'b1;
			bus.processor_addr_strobe_n <= 1'b1;
			bus.chip_select_first_n <= 1'b1;
			bus.burst_advance_n <= 1'b1;
			bus.all_bytes_write_n <= 1'b1;
			bus.byte_lane_write_enable_n <= 1'b1;
			bus.byte_lane_select_n <= '1;
			bus.output_enable_n <= 1'b1;
			bus.sleep_request <= 1'b0;
			bus.burst_order <= 1'b1;
			bus.dq_host <= '0;
			bus.parity_host <= '0;
			bus.dq_host_oe <= 1'b0;
			o_busy <= 1'b0;
			o_rvalid <= 1'b0;
			o_rdata <= '0;
			o_rpar <= '0;
		end else begin
			st <= next_st;
			wr <= next_wr;
			bus.sleep_request <= i_sleep;
			bus.burst_order <= i_interleaved;
			o_busy <= (next_st != FBSP_H_IDLE);
			o_rvalid <= 1'b0;
			bus.controller_addr_strobe_n <= 1'b1;
			bus.processor_addr_strobe_n <= 1'b1;
			bus.all_bytes_write_n <= 1'b1;
			bus.byte_lane_write_enable_n <= 1'b1;
			bus.byte_lane_select_n <= '1;
			bus.dq_host_oe <= 1'b0;
			if (st == FBSP_H_IDLE && i_req) begin
				bus.addr <= i_addr;
				bus.chip_select_first_n <= 1'b0;
				// writes need the controller strobe to carry write controls;
				// processor reads lower both strobes so the device must pick one
				bus.processor_addr_strobe_n <= !(i_use_processor && !i_write);
				bus.controller_addr_strobe_n <= 1'b0;
				bus.all_bytes_write_n <= !(i_write && i_all_bytes);
				bus.byte_lane_write_enable_n <= !i_write;
				bus.byte_lane_select_n <= ~i_lanes;
				bus.output_enable_n <= i_write;
			end
			if (st == FBSP_H_ADDR && wr) begin
				bus.dq_host <= i_wdata;
				bus.parity_host <= i_wpar;
				bus.dq_host_oe <= 1'b1;
			end
			// sampled late: the synced output enable costs the device two edges
			if (st == FBSP_H_TURN && !wr) begin
				o_rvalid <= 1'b1;
				// an undriven bus reads as the inverse, so a missing drive shows
				o_rdata <= bus.dq_dev_oe ? bus.dq_dev : ~bus.dq_dev;
				o_rpar <= bus.dq_dev_oe ? bus.parity_dev : ~bus.parity_dev;
			end
			if (st == FBSP_H_TURN) begin
				bus.chip_select_first_n <= 1'b1;
				// idle with the enable low so the next read finds it settled
				bus.output_enable_n <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// [fbsp_properties.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fbsp_cfg.svh"
module fbsp_properties (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic controller_addr_strobe_n,
	input wire logic processor_addr_strobe_n,
	input wire logic chip_select_first_n,
	input wire logic burst_advance_n,
	input wire logic all_bytes_write_n,
	input wire logic byte_lane_write_enable_n,
	input wire logic output_enable_n,
	input wire logic sleep_request,
	input wire logic dq_host_oe,
	input wire logic [`FBSP_DATA_W-1:0] dq_dev,
	input wire logic [`FBSP_LANES-1:0] parity_dev,
	input wire logic dq_dev_oe
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_srst);
	// five samples cover the two-flop sync plus the output register
	a_oe_floats: assert property (output_enable_n && $past(output_enable_n) &&
		$past(output_enable_n, 2) && $past(output_enable_n, 3) && $past(output_enable_n, 4)
		|-> !dq_dev_oe) else $error("drive with output enable high");
	a_write_no_drive: assert property (dq_host_oe |-> !dq_dev_oe)
		else $error("device drives in write data phase");
	a_sleep_float: assert property (sleep_request [*5] |-> !dq_dev_oe)
		else $error("device drives while asleep");
	a_hold_output: assert property (dq_dev_oe && $past(dq_dev_oe) && $past(burst_advance_n) &&
		$past(controller_addr_strobe_n) && $past(processor_addr_strobe_n)
		|-> $stable(dq_dev) && $stable(parity_dev)) else $error("read data moved without cause");
	a_write_data_follows: assert property (!controller_addr_strobe_n &&
		processor_addr_strobe_n && !chip_select_first_n &&
		(!all_bytes_write_n || !byte_lane_write_enable_n) |=> dq_host_oe)
		else $error("write data not presented one edge after strobe");
	a_proc_read_only: assert property (!processor_addr_strobe_n && !chip_select_first_n
		|=> !dq_host_oe) else $error("processor strobe cycle drove data");
	a_data_after_strobe: assert property ($rose(dq_host_oe) |->
		$past(!controller_addr_strobe_n)) else $error("write data without address strobe");
	// after reset the device counts as deselected, so the first clock is quiet
	a_reset_quiet: assert property ($fell(i_srst) |-> !dq_dev_oe &&
		controller_addr_strobe_n && processor_addr_strobe_n) else $error("activity right after reset");
endmodule
`default_nettype wire

// [flowthrough_burst_sram_port_test.sv]
`timescale 1ns/1ps
`default_nettype none
module flowthrough_burst_sram_port_test;
	import fbsp_pkg::*;
	logic clk = 0, srst = 1, req = 0, wr = 0, prc = 0, ab = 0, slp = 0, il = 1;
	fbsp_addr_t a = '0;
	fbsp_data_t d = '0;
	fbsp_lane_t p = '0, ln = '0;
	logic busy, rv, sl, bi;
	fbsp_data_t rd;
	fbsp_lane_t rp;
	int n_mismatch = 0, num_checks = 0;
	fbsp_if bus();
	fbsp_device u_fbsp_device(.i_clk(clk), .i_srst(srst), .bus(bus.device), .o_sleeping(sl),
		.o_burst_interleaved(bi));
	fbsp_host u_fbsp_host(.i_clk(clk), .i_srst(srst), .bus(bus.host), .i_req(req), .i_write(wr),
		.i_use_processor(prc), .i_addr(a), .i_wdata(d), .i_wpar(p), .i_lanes(ln), .i_all_bytes(ab),
		.i_sleep(slp), .i_interleaved(il), .o_busy(busy), .o_rvalid(rv), .o_rdata(rd), .o_rpar(rp));
	fbsp_properties u_fbsp_properties(.i_clk(clk), .i_srst(srst),
		.controller_addr_strobe_n(bus.controller_addr_strobe_n),
		.processor_addr_strobe_n(bus.processor_addr_strobe_n),
		.chip_select_first_n(bus.chip_select_first_n), .burst_advance_n(bus.burst_advance_n),
		.all_bytes_write_n(bus.all_bytes_write_n),
		.byte_lane_write_enable_n(bus.byte_lane_write_enable_n),
		.output_enable_n(bus.output_enable_n), .sleep_request(bus.sleep_request),
		.dq_host_oe(bus.dq_host_oe), .dq_dev(bus.dq_dev), .parity_dev(bus.parity_dev),
		.dq_dev_oe(bus.dq_dev_oe));
	initial begin
		forever #20 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [35:0] s, input logic [35:0] e);
		num_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	// inputs move at the falling edge, away from the sampling edge
	task automatic go(input logic w, input logic pr, input fbsp_addr_t ad, input fbsp_data_t dd,
		input fbsp_lane_t pp, input fbsp_lane_t ll, input logic aa);
		int i = 0;
		while (busy !== 1'b0 && i < 50) begin
			@(negedge clk);
			i++;
		end
		if (i == 50) begin
			n_mismatch++;
			report_and_stop();
		end
		{wr, prc, a, d, p, ln, ab} = {w, pr, ad, dd, pp, ll, aa};
		req = 1;
		@(negedge clk);
		req = 0;
	endtask
	task automatic rdchk(input logic pr, input fbsp_addr_t ad, input logic [35:0] e);
		int i = 0;
		// lane selects low with the enable high: must not write
		go(0, pr, ad, '0, '0, 4'hf, 0);
		while (rv !== 1'b1 && i < 50) begin
			@(negedge clk);
			i++;
		end
		if (i == 50) begin
			n_mismatch++;
			report_and_stop();
		end
		chk({rp, rd}, e);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(negedge clk);
		srst = 0;
		repeat (4) @(negedge clk);
		chk({35'h0, bi}, 36'h1);
		chk({35'h0, sl}, 36'h0);
		go(1, 0, 19'h00003, 32'h11223344, 4'ha, 4'h0, 1);
		rdchk(0, 19'h00003, 36'ha11223344);
		go(1, 0, 19'h00003, 32'haabbccdd, 4'h5, 4'h5, 0);
		rdchk(1, 19'h00003, 36'hf11bb33dd);
		// enable with no lane selected must leave the word alone
		go(1, 0, 19'h00003, 32'h0, 4'h0, 4'h0, 0);
		go(1, 0, 19'h7ffff, 32'h5a5a5a5a, 4'h3, 4'h0, 1);
		rdchk(0, 19'h00003, 36'hf11bb33dd);
		rdchk(1, 19'h7ffff, 36'h35a5a5a5a);
		slp = 1;
		repeat (8) @(negedge clk);
		chk({35'h0, sl}, 36'h1);
		slp = 0;
		il = 0;
		repeat (4) @(negedge clk);
		chk({35'h0, bi}, 36'h0);
		rdchk(0, 19'h7ffff, 36'h35a5a5a5a);
		report_and_stop();
	end
endmodule
`default_nettype wire
